//--- hdl/copper_test_pkg.sv
`default_nettype none
// Shared constants and types of the copper-port test counter bank.
package copper_test_pkg;
    // Register word offsets on the management port.
    localparam logic [4:0] ADDR_CRC_PACKET_COUNTERS = 5'h11;
    localparam logic [4:0] ADDR_CHECKER_CONTROL = 5'h12;
    localparam logic [4:0] ADDR_GENERATOR_GAP_LENGTH = 5'h13;
    localparam logic [4:0] ADDR_LATE_COLLISION_COUNTS_LOW = 5'h17;
    localparam logic [4:0] ADDR_LATE_COLLISION_COUNTS_HIGH = 5'h18;
    localparam logic [4:0] ADDR_LATE_COLLISION_WINDOW = 5'h19;
    // Reset values of the stored registers.
    localparam logic [15:0] RST_CHECKER_CONTROL = 16'h0000;
    localparam logic [15:0] RST_GENERATOR_GAP_LENGTH = 16'h000c;
    localparam logic [15:0] RST_LATE_COLLISION_WINDOW = 16'h0000;
    // Field positions.
    localparam int CTL_COUNTER_RESET_BIT = 4;
    localparam int CTL_STUB_TEST_BIT = 3;
    localparam int GAP_LSB = 0;
    localparam int GAP_MSB = 7;
    localparam int WIN_ADJ_LSB = 8;
    localparam int WIN_ADJ_MSB = 12;
    // Counter width and saturation value.
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_MAX = 8'hff;
    // Counter slots in the counter array.
    localparam int SLOT_PACKETS = 0;
    localparam int SLOT_CRC_ERRORS = 1;
    localparam int SLOT_LC_65_96 = 2;
    localparam int SLOT_LC_97_128 = 3;
    localparam int SLOT_LC_129_192 = 4;
    localparam int SLOT_LC_OVER_192 = 5;
    localparam int NUM_COUNTERS = 6;
    // Transmit byte position width and late-collision bin bounds.
    localparam int POS_W = 12;
    localparam logic [11:0] POS_MAX = 12'hfff;
    localparam logic [11:0] BIN1_FIRST = 12'h041;
    localparam logic [11:0] BIN1_LAST = 12'h060;
    localparam logic [11:0] BIN2_FIRST = 12'h061;
    localparam logic [11:0] BIN2_LAST = 12'h080;
    localparam logic [11:0] BIN3_FIRST = 12'h081;
    localparam logic [11:0] BIN3_LAST = 12'h0c0;
    // Management request as seen by the bank.
    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } mgmt_req_t;
    // Whole state of the bank apart from the counters.
    typedef struct packed {
        logic [15:0]      ctl;
        logic [15:0]      gap;
        logic [15:0]      win;
        logic [8:0]       gap_bytes;
        logic [15:0]      rdata;
        logic             rx_dv_q;
        logic [POS_W-1:0] tx_pos;
        logic             valid;
    } bank_state_t;
endpackage : copper_test_pkg
`default_nettype wire

//--- hdl/sat_counter.sv
`default_nettype none
// Saturating event counter with a clear that never swallows an event.
module sat_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,   // Block clock.
    input  wire logic             i_rstn,  // Asynchronous reset, active low.
    input  wire logic             i_inc,   // Count one event.
    input  wire logic             i_clr,   // Clear the count.
    output logic      [WIDTH-1:0] o_count  // Current count.
);
    logic [WIDTH-1:0] next_count; // Value for the next edge.

    // A clear restarts from zero; an event in the same cycle still counts.
    always_comb
    begin
        next_count = o_count;
        if (i_clr)
        begin
            next_count = '0;
        end
        if (i_inc && (next_count != {WIDTH{1'b1}}))
        begin
            next_count = next_count + 1'b1;
        end
    end

    // Count register.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_count <= '0;
        end
        else
        begin
            o_count <= next_count;
        end
    end
endmodule // sat_counter
`default_nettype wire

//--- hdl/copper_test_counters.sv
// Summary of operation
// RQ1 - Received packet count, upper byte, saturating.
// RQ2 - CRC error count, lower byte, saturating.
// RQ3 - Counts valid only while checker enabled.
// RQ4 - Counter reset bit clears counters, self-clears.
// RQ5 - Bit 3 selects stub test, resets zero.
// RQ6 - Gap length in bytes is field plus one.
// RQ7 - Late collision at bytes 65-96 counted.
// RQ8 - Late collision at bytes 97-128 counted.
// RQ9 - Late collision at bytes 129-192 counted.
// RQ10 - Late collision beyond byte 192 counted.
// RQ11 - Positions and starts taken at internal GMII.
// RQ12 - Late-collision counters saturate, clear on read.
// RQ13 - Window adjust moves first bin earlier.
// RQ14 - Software writes zeros to reserved bits.
// RQ15 - Counter reset zeroes both counts together.
// RQ16 - Event during read-clear is still counted.
`default_nettype none
module copper_test_counters (
    input  wire logic        I_MCLK,         // Block clock, 20 MHz.
    input  wire logic        I_RSTN,         // Asynchronous reset, active low.
    input  wire logic [4:0]  I_ADDR,         // Register word address.
    input  wire logic [15:0] I_WDATA,        // Write data.
    input  wire logic        I_WR,           // Write strobe.
    input  wire logic        I_RD,           // Read strobe.
    input  wire logic        I_HALF_DUPLEX,  // Link runs half duplex.
    input  wire logic        I_CHECKER_EN,   // CRC checker enabled.
    input  wire logic        I_RX_DONE,      // Received frame ended, one cycle.
    input  wire logic        I_RX_CRC_ERR,   // That frame had a CRC error.
    input  wire logic        I_GMII_RX_DV,   // Internal GMII receive valid.
    input  wire logic        I_GMII_TX_EN,   // Internal GMII transmit enable.
    input  wire logic        I_GMII_TX_STB,  // One transmit byte passes.
    output logic      [15:0] O_RDATA,        // Read data, cycle after read.
    output logic             O_STUB_TEST,    // Stub test selected.
    output logic      [8:0]  O_GAP_BYTES,    // Inter-packet gap in bytes.
    output logic             O_COUNTS_VALID  // Packet and CRC counts valid.
);
    // The request fields bundled together.
    copper_test_pkg::mgmt_req_t req;
    // Registered state and its next value.
    copper_test_pkg::bank_state_t st;
    copper_test_pkg::bank_state_t next_st;
    // Per-counter increment and clear requests.
    logic [copper_test_pkg::NUM_COUNTERS-1:0] cnt_inc;
    logic [copper_test_pkg::NUM_COUNTERS-1:0] cnt_clr;
    // Current counter values.
    logic [copper_test_pkg::CNT_W-1:0] cnt [copper_test_pkg::NUM_COUNTERS];
    // Decoded strobes.
    logic wr_ctl;
    logic wr_gap;
    logic wr_win;
    logic rd_lc_low;
    logic rd_lc_high;
    // Packet start seen on the receive side.
    logic rx_start;
    // Lower bound of the first late-collision bin.
    logic [copper_test_pkg::POS_W-1:0] bin1_first;
    // Late-collision event: receive start in half duplex while transmitting.
    logic lc_arm;
    // Counter reset held this cycle.
    logic cnt_reset;

    // Gather the bus signals into one request; all come from this clock.
    assign req.addr = I_ADDR;
    assign req.wdata = I_WDATA;
    assign req.wr = I_WR;
    assign req.rd = I_RD;

    // Address decode of the strobes.
    always_comb
    begin
        wr_ctl = req.wr && (req.addr == copper_test_pkg::ADDR_CHECKER_CONTROL);
        wr_gap = req.wr && (req.addr == copper_test_pkg::ADDR_GENERATOR_GAP_LENGTH);
        wr_win = req.wr && (req.addr == copper_test_pkg::ADDR_LATE_COLLISION_WINDOW);
        rd_lc_low = req.rd && (req.addr == copper_test_pkg::ADDR_LATE_COLLISION_COUNTS_LOW);
        rd_lc_high = req.rd && (req.addr == copper_test_pkg::ADDR_LATE_COLLISION_COUNTS_HIGH);
    end

    // The stored reset bit clears the packet and CRC counts for one cycle.
    assign cnt_reset = st.ctl[copper_test_pkg::CTL_COUNTER_RESET_BIT]; // [RQ4]

    // A packet start is the rising edge of receive valid on the internal
    // GMII; those signals are on this clock, so no synchroniser is needed.
    assign rx_start = I_GMII_RX_DV && !st.rx_dv_q; // [RQ11]

    // Late collisions only count in half duplex while a frame goes out.
    assign lc_arm = I_HALF_DUPLEX && I_GMII_TX_EN && rx_start;

    // Each unit of adjust starts the first bin one byte earlier.
    always_comb
    begin
        bin1_first = copper_test_pkg::BIN1_FIRST
                   - copper_test_pkg::POS_W'(st.win[copper_test_pkg::WIN_ADJ_MSB:
                                                    copper_test_pkg::WIN_ADJ_LSB]); // [RQ13]
    end

    // Increment requests of all six counters.
    always_comb
    begin
        cnt_inc = '0;
        // Receive frames are counted only while the checker runs.
        cnt_inc[copper_test_pkg::SLOT_PACKETS] = I_CHECKER_EN && I_RX_DONE; // [RQ1] [RQ3]
        cnt_inc[copper_test_pkg::SLOT_CRC_ERRORS] = I_CHECKER_EN && I_RX_DONE
                                                  && I_RX_CRC_ERR; // [RQ2] [RQ3]
        // The byte on the wire picks the late-collision bin.
        cnt_inc[copper_test_pkg::SLOT_LC_65_96] = lc_arm
            && (st.tx_pos >= bin1_first)
            && (st.tx_pos <= copper_test_pkg::BIN1_LAST); // [RQ7] [RQ13]
        cnt_inc[copper_test_pkg::SLOT_LC_97_128] = lc_arm
            && (st.tx_pos >= copper_test_pkg::BIN2_FIRST)
            && (st.tx_pos <= copper_test_pkg::BIN2_LAST); // [RQ8]
        cnt_inc[copper_test_pkg::SLOT_LC_129_192] = lc_arm
            && (st.tx_pos >= copper_test_pkg::BIN3_FIRST)
            && (st.tx_pos <= copper_test_pkg::BIN3_LAST); // [RQ9]
        cnt_inc[copper_test_pkg::SLOT_LC_OVER_192] = lc_arm
            && (st.tx_pos > copper_test_pkg::BIN3_LAST); // [RQ10]
    end

    // Clear requests: counter reset for the receive pair, reads for the rest.
    always_comb
    begin
        cnt_clr = '0;
        // Both receive counts drop together on one edge.
        cnt_clr[copper_test_pkg::SLOT_PACKETS] = cnt_reset; // [RQ15]
        cnt_clr[copper_test_pkg::SLOT_CRC_ERRORS] = cnt_reset; // [RQ15]
        // A read empties both bytes of the register read.
        cnt_clr[copper_test_pkg::SLOT_LC_65_96] = rd_lc_low; // [RQ12]
        cnt_clr[copper_test_pkg::SLOT_LC_97_128] = rd_lc_low; // [RQ12]
        cnt_clr[copper_test_pkg::SLOT_LC_129_192] = rd_lc_high; // [RQ12]
        cnt_clr[copper_test_pkg::SLOT_LC_OVER_192] = rd_lc_high; // [RQ12]
    end

    // One saturating counter per slot; an event during a clear counts one.
    generate
        for (genvar g = 0; g < copper_test_pkg::NUM_COUNTERS; g++)
        begin : g_cnt
            sat_counter #(
                .WIDTH (copper_test_pkg::CNT_W)
            ) u_cnt (
                .i_clk   (I_MCLK),
                .i_rstn  (I_RSTN),
                .i_inc   (cnt_inc[g]),
                .i_clr   (cnt_clr[g]),
                .o_count (cnt[g])
            ); // [RQ1] [RQ2] [RQ12] [RQ16]
        end
    endgenerate

    // Next state of registers, byte position and read data.
    always_comb
    begin
        next_st = st;
        next_st.rx_dv_q = I_GMII_RX_DV;
        next_st.valid = I_CHECKER_EN; // [RQ3]

        // The reset bit lives one cycle, then clears itself.
        if (cnt_reset)
        begin
            next_st.ctl[copper_test_pkg::CTL_COUNTER_RESET_BIT] = 1'b0; // [RQ4]
        end

        // Register writes; reserved bits are stored as written, and
        // software is expected to keep them at zero.
        if (wr_ctl)
        begin
            next_st.ctl = req.wdata; // [RQ4] [RQ5] [RQ14]
        end
        if (wr_gap)
        begin
            next_st.gap = req.wdata;
        end
        if (wr_win)
        begin
            next_st.win = req.wdata; // [RQ13] [RQ14]
        end

        // The gap that the generator inserts is one byte above the field.
        next_st.gap_bytes = {1'b0, next_st.gap[copper_test_pkg::GAP_MSB:
                                               copper_test_pkg::GAP_LSB]}
                          + 9'h001; // [RQ6]

        // Byte position on the internal GMII transmit side: number of
        // the byte now on the wire, zero outside a frame.
        if (!I_GMII_TX_EN)
        begin
            next_st.tx_pos = '0; // [RQ11]
        end
        else if (I_GMII_TX_STB && (st.tx_pos != copper_test_pkg::POS_MAX))
        begin
            next_st.tx_pos = st.tx_pos + 1'b1; // [RQ11]
        end

        // Read data stand only in the cycle after the read strobe.
        next_st.rdata = 16'h0000;
        if (req.rd)
        begin
            case (req.addr)
                copper_test_pkg::ADDR_CRC_PACKET_COUNTERS:
                begin
                    // Packet count high byte, CRC errors low byte.
                    next_st.rdata = {cnt[copper_test_pkg::SLOT_PACKETS],
                                     cnt[copper_test_pkg::SLOT_CRC_ERRORS]}; // [RQ1] [RQ2]
                end
                copper_test_pkg::ADDR_CHECKER_CONTROL:
                begin
                    next_st.rdata = st.ctl;
                end
                copper_test_pkg::ADDR_GENERATOR_GAP_LENGTH:
                begin
                    next_st.rdata = st.gap;
                end
                copper_test_pkg::ADDR_LATE_COLLISION_COUNTS_LOW:
                begin
                    next_st.rdata = {cnt[copper_test_pkg::SLOT_LC_97_128],
                                     cnt[copper_test_pkg::SLOT_LC_65_96]};
                end
                copper_test_pkg::ADDR_LATE_COLLISION_COUNTS_HIGH:
                begin
                    next_st.rdata = {cnt[copper_test_pkg::SLOT_LC_OVER_192],
                                     cnt[copper_test_pkg::SLOT_LC_129_192]};
                end
                copper_test_pkg::ADDR_LATE_COLLISION_WINDOW:
                begin
                    next_st.rdata = st.win;
                end
                default:
                begin
                    // Unmapped addresses read as zero.
                    next_st.rdata = 16'h0000;
                end
            endcase
        end
    end

    // State register with hardware reset values.
    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            st.ctl <= copper_test_pkg::RST_CHECKER_CONTROL; // [RQ5]
            st.gap <= copper_test_pkg::RST_GENERATOR_GAP_LENGTH; // [RQ6]
            st.win <= copper_test_pkg::RST_LATE_COLLISION_WINDOW;
            st.gap_bytes <= 9'h00d;
            st.rdata <= 16'h0000;
            st.rx_dv_q <= 1'b0;
            st.tx_pos <= '0;
            st.valid <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state flip-flops.
    assign O_RDATA = st.rdata;
    assign O_STUB_TEST = st.ctl[copper_test_pkg::CTL_STUB_TEST_BIT]; // [RQ5]
    assign O_GAP_BYTES = st.gap_bytes; // [RQ6]
    assign O_COUNTS_VALID = st.valid; // [RQ3]
endmodule // copper_test_counters
`default_nettype wire

//--- verif/copper_test_counters_chk.sv
`default_nettype none
// Port-level checker of the copper-port test counter bank.
module copper_test_counters_chk (
    input wire logic        I_MCLK,         // Block clock.
    input wire logic        I_RSTN,         // Reset, active low.
    input wire logic [4:0]  I_ADDR,         // Register address.
    input wire logic [15:0] I_WDATA,        // Write data.
    input wire logic        I_WR,           // Write strobe.
    input wire logic        I_RD,           // Read strobe.
    input wire logic        I_HALF_DUPLEX,  // Half duplex.
    input wire logic        I_CHECKER_EN,   // Checker enabled.
    input wire logic        I_RX_DONE,      // Frame ended.
    input wire logic        I_RX_CRC_ERR,   // Frame had an error.
    input wire logic        I_GMII_RX_DV,   // Receive valid.
    input wire logic        I_GMII_TX_EN,   // Transmit enable.
    input wire logic        I_GMII_TX_STB,  // Transmit byte.
    input wire logic [15:0] O_RDATA,        // Read data.
    input wire logic        O_STUB_TEST,    // Stub test.
    input wire logic [8:0]  O_GAP_BYTES,    // Gap in bytes.
    input wire logic        O_COUNTS_VALID  // Counts valid.
);
    timeunit 1ns;
    timeprecision 1ns;
    // All checks run on the block clock and pause during reset.
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);
    // Read data show only in the cycle after a read.
    AST_RDATA_IDLE: assert property (!I_RD |=> O_RDATA == 16'h0000)
        else $error("read data not idle");
    // An unmapped address reads as zero.
    AST_UNMAPPED: assert property (I_RD && I_ADDR == 5'h00 |=> O_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    // The gap output follows the written field plus one.
    AST_GAP: assert property (I_WR && I_ADDR == copper_test_pkg::ADDR_GENERATOR_GAP_LENGTH ##1 !I_WR [*2] |-> O_GAP_BYTES == {1'b0, $past(I_WDATA[7:0], 2)} + 9'd1)
        else $error("gap bytes wrong");
    // The stub test output follows control bit 3.
    AST_STUB: assert property (I_WR && I_ADDR == copper_test_pkg::ADDR_CHECKER_CONTROL ##1 !I_WR [*2] |-> O_STUB_TEST == $past(I_WDATA[3], 2))
        else $error("stub test wrong");
    // Count validity tracks the checker enable one cycle late.
    AST_VALID: assert property (O_COUNTS_VALID == $past(I_CHECKER_EN))
        else $error("counts valid wrong");
    // A second read of the low late-collision register without events gives zero.
    AST_LC_CLEAR: assert property (I_RD && I_ADDR == copper_test_pkg::ADDR_LATE_COLLISION_COUNTS_LOW && !I_GMII_RX_DV ##1 I_RD && I_ADDR == copper_test_pkg::ADDR_LATE_COLLISION_COUNTS_LOW && !I_GMII_RX_DV |=> O_RDATA == 16'h0000)
        else $error("late count not cleared");
    // A counter reset zeroes both receive counts.
    AST_CRC_RESET: assert property (I_WR && I_ADDR == copper_test_pkg::ADDR_CHECKER_CONTROL && I_WDATA[4] ##1 !I_RX_DONE ##1 I_RD && I_ADDR == copper_test_pkg::ADDR_CRC_PACKET_COUNTERS |=> O_RDATA == 16'h0000)
        else $error("receive counts not reset");
    // The counter reset bit clears itself.
    AST_CTL_SC: assert property (I_WR && I_ADDR == copper_test_pkg::ADDR_CHECKER_CONTROL && I_WDATA[4] ##1 !I_WR ##1 I_RD && I_ADDR == copper_test_pkg::ADDR_CHECKER_CONTROL |=> !O_RDATA[4])
        else $error("reset bit stuck");
    // Main scenarios reached.
    COV_LC_READ: cover property (I_RD && I_ADDR == copper_test_pkg::ADDR_LATE_COLLISION_COUNTS_HIGH);
    COV_CRC_RESET: cover property (I_WR && I_ADDR == copper_test_pkg::ADDR_CHECKER_CONTROL && I_WDATA[4]);
    COV_GAP_WRITE: cover property (I_WR && I_ADDR == copper_test_pkg::ADDR_GENERATOR_GAP_LENGTH);
endmodule // copper_test_counters_chk
bind copper_test_counters copper_test_counters_chk i_copper_test_counters_chk (
    .I_MCLK, .I_RSTN, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_HALF_DUPLEX, .I_CHECKER_EN,
    .I_RX_DONE, .I_RX_CRC_ERR, .I_GMII_RX_DV, .I_GMII_TX_EN, .I_GMII_TX_STB,
    .O_RDATA, .O_STUB_TEST, .O_GAP_BYTES, .O_COUNTS_VALID);
`default_nettype wire

//--- verif/tb.sv
`default_nettype none
// Self-checking bench of the copper-port test counter bank.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        I_MCLK = 1'b0, I_RSTN = 1'b0, I_WR = 1'b0, I_RD = 1'b0;
    logic        I_HALF_DUPLEX = 1'b1, I_CHECKER_EN = 1'b0, I_RX_DONE = 1'b0;
    logic        I_RX_CRC_ERR = 1'b0, I_GMII_RX_DV = 1'b0, I_GMII_TX_EN = 1'b0;
    logic        I_GMII_TX_STB = 1'b0, O_STUB_TEST, O_COUNTS_VALID;
    logic [4:0]  I_ADDR = 5'h00;      // Register address.
    logic [15:0] I_WDATA = 16'h0000;  // Write data.
    logic [15:0] O_RDATA;             // Read data.
    logic [8:0]  O_GAP_BYTES;         // Gap in bytes.
    logic [31:0] e;                   // Expected late counts.
    int          err_count = 0, num_checks = 0;
    int          pos [8] = '{64, 65, 96, 97, 128, 129, 192, 193};
    copper_test_counters i_copper_test_counters (
        .I_MCLK, .I_RSTN, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_HALF_DUPLEX, .I_CHECKER_EN,
        .I_RX_DONE, .I_RX_CRC_ERR, .I_GMII_RX_DV, .I_GMII_TX_EN, .I_GMII_TX_STB,
        .O_RDATA, .O_STUB_TEST, .O_GAP_BYTES, .O_COUNTS_VALID);
    // Clock of 50 ns period.
    initial forever #25 I_MCLK = ~I_MCLK;
    // Compares one value and counts it.
    task automatic eq(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Drives one bus cycle just after a rising edge.
    task automatic cyc(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
        @(posedge I_MCLK);
        I_WR <= w;
        I_RD <= r;
        I_ADDR <= a;
        I_WDATA <= d;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        cyc(1'b1, 1'b0, a, d);
        cyc(1'b0, 1'b0, a, d);
    endtask
    // Reads and checks in the cycle after the strobe.
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        cyc(1'b0, 1'b1, a, 16'h0000);
        cyc(1'b0, 1'b0, a, 16'h0000);
        #1;
        eq(O_RDATA, exp);
    endtask
    // One received frame end.
    task automatic rxf(input logic crc);
        @(posedge I_MCLK);
        I_RX_DONE <= 1'b1;
        I_RX_CRC_ERR <= crc;
        @(posedge I_MCLK);
        I_RX_DONE <= 1'b0;
    endtask
    // Sends n bytes, then a receive start arrives.
    task automatic lc(input int n);
        @(posedge I_MCLK);
        I_GMII_TX_EN <= 1'b1;
        repeat (n) @(posedge I_MCLK) I_GMII_TX_STB <= 1'b1;
        @(posedge I_MCLK);
        I_GMII_TX_STB <= 1'b0;
        I_GMII_RX_DV <= 1'b1;
        @(posedge I_MCLK);
        I_GMII_RX_DV <= 1'b0;
        I_GMII_TX_EN <= 1'b0;
    endtask
    // Expected {0x18, 0x17} after one collision at byte p.
    function automatic logic [31:0] lc_exp(input int p, input int adj);
        if (p >= 65 - adj && p <= 96) return 32'h0000_0001;
        if (p >= 97 && p <= 128) return 32'h0000_0100;
        if (p >= 129 && p <= 192) return 32'h0001_0000;
        if (p > 192) return 32'h0100_0000;
        return 32'h0000_0000;
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog far beyond the expected run length.
    initial
    begin
        #2_000_000;
        err_count++;
        close_out();
    end
    // Main sequence.
    initial
    begin
        repeat (8) @(posedge I_MCLK);
        I_RSTN <= 1'b1;
        rd(5'h11, 16'h0000);
        rd(5'h12, 16'h0000);
        rd(5'h13, 16'h000c);
        rd(5'h17, 16'h0000);
        rd(5'h18, 16'h0000);
        rd(5'h19, 16'h0000);
        rd(5'h00, 16'h0000);
        eq({7'h00, O_GAP_BYTES}, 16'h000d);
        $display("reset values done");
        wr(5'h12, 16'h0008);
        rd(5'h12, 16'h0008);
        eq({15'h0000, O_STUB_TEST}, 16'h0001);
        wr(5'h13, 16'h00ff);
        rd(5'h13, 16'h00ff);
        eq({7'h00, O_GAP_BYTES}, 16'h0100);
        wr(5'h13, 16'h0000);
        rd(5'h13, 16'h0000);
        eq({7'h00, O_GAP_BYTES}, 16'h0001);
        $display("control fields done");
        @(posedge I_MCLK) I_CHECKER_EN <= 1'b1;
        rxf(1'b1);
        rxf(1'b1);
        rxf(1'b0);
        rd(5'h11, 16'h0302);
        eq({15'h0000, O_COUNTS_VALID}, 16'h0001);
        @(posedge I_MCLK) I_CHECKER_EN <= 1'b0;
        rxf(1'b1);
        rd(5'h11, 16'h0302);
        @(posedge I_MCLK) I_CHECKER_EN <= 1'b1;
        repeat (300) rxf(1'b1);
        wr(5'h11, 16'h1234);
        rd(5'h11, 16'hffff);
        wr(5'h12, 16'h0010);
        rd(5'h11, 16'h0000);
        rxf(1'b1);
        wr(5'h12, 16'h0010);
        rd(5'h12, 16'h0000);
        rd(5'h11, 16'h0000);
        $display("receive counters done");
        for (int adj = 0; adj < 2; adj++)
        begin
            wr(5'h19, 16'(adj) << 8);
            foreach (pos[k])
            begin
                e = lc_exp(pos[k], adj);
                lc(pos[k]);
                rd(5'h17, e[15:0]);
                rd(5'h18, e[31:16]);
            end
        end
        @(posedge I_MCLK) I_HALF_DUPLEX <= 1'b0;
        lc(100);
        rd(5'h17, 16'h0000);
        @(posedge I_MCLK) I_HALF_DUPLEX <= 1'b1;
        wr(5'h19, 16'h1f00);
        rd(5'h19, 16'h1f00);
        lc(33);
        rd(5'h17, 16'h0000);
        repeat (260) lc(34);
        rd(5'h17, 16'h00ff);
        lc(34);
        lc(34);
        cyc(1'b0, 1'b1, 5'h17, 16'h0000);
        cyc(1'b0, 1'b1, 5'h17, 16'h0000);
        #1 eq(O_RDATA, 16'h0002);
        cyc(1'b0, 1'b0, 5'h00, 16'h0000);
        #1 eq(O_RDATA, 16'h0000);
        // A collision that lands on the clearing read must still be counted.
        @(posedge I_MCLK) I_GMII_TX_EN <= 1'b1;
        repeat (34) @(posedge I_MCLK) I_GMII_TX_STB <= 1'b1;
        @(posedge I_MCLK);
        I_GMII_TX_STB <= 1'b0;
        I_GMII_RX_DV <= 1'b1;
        I_RD <= 1'b1;
        I_ADDR <= 5'h17;
        @(posedge I_MCLK);
        I_GMII_RX_DV <= 1'b0;
        I_GMII_TX_EN <= 1'b0;
        I_RD <= 1'b0;
        #1 eq(O_RDATA, 16'h0000);
        rd(5'h17, 16'h0001);
        $display("late collisions done");
        close_out();
    end
endmodule // tb
`default_nettype wire
